// file: src/cbsc_pkg.sv
// constants shared by the core buffer staging control block and its fifo
package cbsc_pkg;

    // --------------------
    // geometry
    // --------------------
    localparam int HALF_WORD_BITS = 42; // bits moved in one parallel half-word
    localparam int STAGE_DEPTH = 8;     // words per staging register
    localparam int FIFO_DEPTH = 4;      // tape word buffer entries

    // --------------------
    // pulse timing, in nanoseconds as printed, and derived cycle counts
    // --------------------
    localparam int CLK_PERIOD_NS = 100;  // clk_sys at 10 MHz
    localparam int SHORT_PULSE_NS = 200; // zero readout pulse
    localparam int LONG_PULSE_NS = 1000; // one readout pulse
    localparam int TAPE_PULSE_NS = 2000; // tape buffer readout pulse

    // durations are emitted, so round down, never below one cycle
    localparam int SHORT_CYC_I = (SHORT_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
        SHORT_PULSE_NS / CLK_PERIOD_NS;
    localparam int LONG_CYC_I = (LONG_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
        LONG_PULSE_NS / CLK_PERIOD_NS;
    localparam int TAPE_CYC_I = (TAPE_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
        TAPE_PULSE_NS / CLK_PERIOD_NS;

    // width of every pulse timer and duration counter
    localparam int CNT_W = 5;

    localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(SHORT_CYC_I);
    localparam logic [CNT_W-1:0] LONG_CYC = CNT_W'(LONG_CYC_I);
    localparam logic [CNT_W-1:0] TAPE_CYC = CNT_W'(TAPE_CYC_I);
    // an incoming pulse held longer than a short one counts as a one
    localparam logic [CNT_W-1:0] SET_MIN_CYC = CNT_W'(SHORT_CYC_I + 1);
    // timer values above these still belong to the short part of a pulse
    localparam logic [CNT_W-1:0] LONG_SHORT_EDGE = CNT_W'(LONG_CYC_I - SHORT_CYC_I);
    localparam logic [CNT_W-1:0] TAPE_SHORT_EDGE = CNT_W'(TAPE_CYC_I - SHORT_CYC_I);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

endpackage

// file: src/cbsc_stream_if.sv
// valid/ready word stream between the staging block and its fifo
`timescale 1ns/1ps
`default_nettype none

interface cbsc_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;             // word offered
    logic ready;             // word can be taken
    logic [WIDTH-1:0] data;  // the word

    // producer side
    modport src(output valid, output data, input ready);
    // consumer side
    modport snk(input valid, input data, output ready);
endinterface

`default_nettype wire

// file: src/cbsc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module cbsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill and drain sides
    cbsc_stream_if.snk in_s,
    cbsc_stream_if.src out_s
);
    import cbsc_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

    // --------------------
    // state
    // --------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // entries
        logic [PTR_W-1:0] wr;             // next slot to fill
        logic [PTR_W-1:0] rd;             // oldest entry
        logic [PTR_W:0] cnt;              // entries held
        logic [WIDTH-1:0] head;           // copy of the oldest entry
        logic vld;                        // entries present
    } cbsc_fifo_s;

    cbsc_fifo_s st_reg;
    cbsc_fifo_s st_next;
    logic push;
    logic pop;

    // honest flags straight from the entry count
    assign in_s.ready = (st_reg.cnt != CNT_FULL);
    assign out_s.valid = st_reg.vld;
    assign out_s.data = st_reg.head;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // next state: write, read, and count both in one cycle
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_s.data;
            st_next.wr = (st_reg.wr == PTR_LAST) ? '0 : st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = (st_reg.rd == PTR_LAST) ? '0 : st_reg.rd + 1'b1;
        end
        // simultaneous push and pop leave the count alone
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        // drain side comes straight from flops, no mux after them
        st_next.vld = (st_next.cnt != '0);
        st_next.head = st_next.mem[st_next.rd];
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // cbsc_fifo

`default_nettype wire

// file: src/cbsc_core_buffer_staging.sv
// bit-slice staging control for the input and output staging registers
// What this block does
// - long distributor pulse sets input buffer core
// - buffer one with restore gate drives inhibit
// - buffer zero gives no inhibit, memory one
// - input inhibit held until terminate pulse
// - preset input buffer, sense strobe clears it
// - input buffer read sends long pulse, restores
// - long memory-side pulse sets output buffer core
// - output buffer one with restore gate inhibits
// - terminate pulse ends held output inhibit
// - preset output buffer, sense strobe clears it
// - output read copies ones into tape buffer
// - output read with restore rewrites output register
// - tape readout answers long one, short zero
// - tape buffer sets write flip-flops per bit
// - parallel half-word, one buffer bit per position
`timescale 1ns/1ps
`default_nettype none

module cbsc_core_buffer_staging #(
    parameter int W = cbsc_pkg::HALF_WORD_BITS,   // bits per half-word
    parameter int DEPTH = cbsc_pkg::STAGE_DEPTH,  // words per staging register
    parameter int QDEPTH = cbsc_pkg::FIFO_DEPTH,  // tape word fifo entries
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // incoming bit pulses, one line per bit position
    input wire logic [W-1:0] dist_line,
    input wire logic [W-1:0] mside_in_line,
    // presets and sense strobes from central sequencing
    input wire logic buffer_preset_in,
    input wire logic buffer_preset_out,
    input wire logic input_sense_strobe,
    input wire logic output_sense_strobe,
    input wire logic [AW-1:0] stage_addr,
    // buffer reads and their companion gates
    input wire logic input_buffer_read,
    input wire logic input_restore_gate,
    input wire logic output_buffer_read,
    input wire logic output_restore_gate,
    input wire logic output_to_tape_transfer,
    // staging register write half and inhibit end
    input wire logic input_write_pulse,
    input wire logic output_write_pulse,
    input wire logic inhibit_terminate_pulse,
    // tape side request
    input wire logic tape_readout_pulse,
    // pulse outputs toward the memory-side buffer and tape
    output logic [W-1:0] mside_out_line,
    output logic [W-1:0] tape_line,
    // held levels
    output logic [W-1:0] tape_write_ff,
    output logic [W-1:0] input_inhibit,
    output logic [W-1:0] output_inhibit,
    output logic tape_busy,
    // buffered tape words
    output logic tape_word_valid,
    output logic [W-1:0] tape_word_data,
    input wire logic tape_word_ready
);
    import cbsc_pkg::*;

    // --------------------
    // state of the whole block
    // --------------------
    // the staging registers hold memory polarity: a core at one is a
    // machine zero, which keeps sense and inhibit logic as plain as the
    // hardware it stands for
    typedef struct packed {
        logic [W-1:0] in_buf;                 // input buffer cores
        logic [W-1:0] out_buf;                // output buffer cores
        logic [W-1:0] tape_buf;               // tape buffer cores
        logic [W-1:0] in_inh;                 // input inhibit stretchers
        logic [W-1:0] out_inh;                // output inhibit stretchers
        logic [W-1:0] wr_ff;                  // tape write flip-flops
        logic [DEPTH-1:0][W-1:0] in_reg;      // input staging register
        logic [DEPTH-1:0][W-1:0] out_reg;     // output staging register
        logic [W-1:0][CNT_W-1:0] dist_cnt;    // distributor pulse lengths
        logic [W-1:0][CNT_W-1:0] mside_cnt;   // memory-side pulse lengths
        logic [CNT_W-1:0] ms_cnt;             // memory-side pulse timer
        logic [CNT_W-1:0] tp_cnt;             // tape pulse timer
        logic [W-1:0] ms_bits;                // bits being sent to memory side
        logic [W-1:0] tp_bits;                // bits being sent to tape
        logic [W-1:0] ms_line;                // memory-side pulse levels
        logic [W-1:0] tp_line;                // tape pulse levels
        logic tro_prev;                       // tape readout seen last cycle
        logic push_v;                         // tape word waiting for fifo
    } cbsc_state_s;

    cbsc_state_s st_reg;   // registered state
    cbsc_state_s st_next;  // next state

    // fifo links
    cbsc_stream_if #(.WIDTH(W)) push_if();
    cbsc_stream_if #(.WIDTH(W)) pop_if();

    // --------------------
    // next state
    // --------------------
    // steps are applied in the order sequencing issues them within one
    // bit time: capture, preset, sense, read, write, terminate; when two
    // land in the same cycle the later step sees the earlier one's result
    always_comb begin
        st_next = st_reg;

        // -- running pulse timers count down to idle
        if (st_reg.ms_cnt != CNT_ZERO) begin
            st_next.ms_cnt = st_reg.ms_cnt - CNT_ONE;
        end
        if (st_reg.tp_cnt != CNT_ZERO) begin
            st_next.tp_cnt = st_reg.tp_cnt - CNT_ONE;
        end

        // -- incoming pulse length decides the bit value
        // a short pulse never reaches the count and leaves the core as is
        for (int i = 0; i < W; i++) begin
            if (dist_line[i]) begin
                if (st_reg.dist_cnt[i] != SET_MIN_CYC) begin
                    st_next.dist_cnt[i] = st_reg.dist_cnt[i] + CNT_ONE;
                end
            end else begin
                st_next.dist_cnt[i] = CNT_ZERO;
            end
            if (st_next.dist_cnt[i] == SET_MIN_CYC) begin
                st_next.in_buf[i] = 1'b1;
            end
            if (mside_in_line[i]) begin
                if (st_reg.mside_cnt[i] != SET_MIN_CYC) begin
                    st_next.mside_cnt[i] = st_reg.mside_cnt[i] + CNT_ONE;
                end
            end else begin
                st_next.mside_cnt[i] = CNT_ZERO;
            end
            if (st_next.mside_cnt[i] == SET_MIN_CYC) begin
                st_next.out_buf[i] = 1'b1;
            end
        end

        // -- buffer_preset_pulse ahead of a register sense
        if (buffer_preset_in) begin
            st_next.in_buf = '1;
        end
        if (buffer_preset_out) begin
            st_next.out_buf = '1;
        end

        // -- sense: a memory one clears the buffer bit, giving machine
        // polarity; the core read itself leaves the word cleared
        if (input_sense_strobe) begin
            st_next.in_buf = st_next.in_buf & ~st_reg.in_reg[stage_addr];
            st_next.in_reg[stage_addr] = '0;
        end
        if (output_sense_strobe) begin
            st_next.out_buf = st_next.out_buf & ~st_reg.out_reg[stage_addr];
            st_next.out_reg[stage_addr] = '0;
        end

        // -- input buffer read, toward the memory-side buffer
        if (input_buffer_read) begin
            st_next.ms_bits = st_next.in_buf;
            st_next.ms_cnt = LONG_CYC;
            if (input_restore_gate) begin
                // only a one gets through to the stretcher
                st_next.in_inh = st_reg.in_inh | st_next.in_buf;
            end
            st_next.in_buf = '0;
        end

        // -- output buffer read, toward tape and back into the register
        if (output_buffer_read) begin
            if (output_to_tape_transfer) begin
                st_next.tape_buf = st_reg.tape_buf | st_next.out_buf;
            end
            if (output_restore_gate) begin
                st_next.out_inh = st_reg.out_inh | st_next.out_buf;
            end
            st_next.out_buf = '0;
        end

        // -- write half: memory one everywhere not inhibited
        if (input_write_pulse) begin
            st_next.in_reg[stage_addr] = ~st_next.in_inh;
        end
        if (output_write_pulse) begin
            st_next.out_reg[stage_addr] = ~st_next.out_inh;
        end

        // -- inhibit held until discharged; termination wins over a
        // stretcher input landing in the same cycle, as the capacitor
        // discharge would
        if (inhibit_terminate_pulse) begin
            st_next.in_inh = '0;
            st_next.out_inh = '0;
        end

        // -- tape side handshake to the fifo finishes
        if (st_reg.push_v && push_if.ready) begin
            st_next.push_v = 1'b0;
        end

        // -- tape readout on the rising edge of the request
        // refused while the previous word still waits for the fifo, so
        // back-pressure stops the tape buffer from being emptied
        st_next.tro_prev = tape_readout_pulse;
        if (tape_readout_pulse && !st_reg.tro_prev && !st_reg.push_v) begin
            st_next.tp_bits = st_reg.tape_buf;
            st_next.tp_cnt = TAPE_CYC;
            st_next.wr_ff = st_reg.tape_buf;
            st_next.tape_buf = '0;
            st_next.push_v = 1'b1;
        end

        // -- pulse shapes: ones run the full timer, zeros only the head
        if (st_next.ms_cnt == CNT_ZERO) begin
            st_next.ms_line = '0;
        end else if (st_next.ms_cnt > LONG_SHORT_EDGE) begin
            st_next.ms_line = '1;
        end else begin
            st_next.ms_line = st_next.ms_bits;
        end
        if (st_next.tp_cnt == CNT_ZERO) begin
            st_next.tp_line = '0;
        end else if (st_next.tp_cnt > TAPE_SHORT_EDGE) begin
            st_next.tp_line = '1;
        end else begin
            st_next.tp_line = st_next.tp_bits;
        end
    end

    // --------------------
    // state register
    // --------------------
    // synchronous reset: cores, stretchers and timers all start cleared
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // --------------------
    // tape word fifo
    // --------------------
    // holds each word latched into the write flip-flops until the tape
    // side takes it; with the fifo full, one more word waits in the write flip-flops and further readouts stall
    assign push_if.valid = st_reg.push_v;
    assign push_if.data = st_reg.wr_ff;
    assign pop_if.ready = tape_word_ready;

    cbsc_fifo #(
        .WIDTH(W),
        .DEPTH(QDEPTH)
    ) u_tape_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_s(push_if),
        .out_s(pop_if)
    );

    // --------------------
    // outputs
    // --------------------
    // all levels and pulses come from state flip-flops
    assign mside_out_line = st_reg.ms_line;
    assign tape_line = st_reg.tp_line;
    assign tape_write_ff = st_reg.wr_ff;
    assign input_inhibit = st_reg.in_inh;
    assign output_inhibit = st_reg.out_inh;
    assign tape_busy = st_reg.push_v;
    // fifo head and valid come from the fifo's own flops
    assign tape_word_valid = pop_if.valid;
    assign tape_word_data = pop_if.data;

endmodule // cbsc_core_buffer_staging

`default_nettype wire

// file: verif/cbsc_core_buffer_staging_asserts.sv
// concurrent checks on the staging block's top-level ports
`timescale 1ns/1ps
`default_nettype none

module cbsc_core_buffer_staging_asserts #(
    parameter int W = cbsc_pkg::HALF_WORD_BITS  // bits per half-word
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // sequencing pulses
    input wire logic input_buffer_read,
    input wire logic input_restore_gate,
    input wire logic inhibit_terminate_pulse,
    // pulse and level outputs
    input wire logic [W-1:0] mside_out_line,
    input wire logic [W-1:0] tape_line,
    input wire logic [W-1:0] input_inhibit,
    input wire logic [W-1:0] output_inhibit,
    input wire logic tape_busy,
    // buffered tape words
    input wire logic tape_word_valid,
    input wire logic [W-1:0] tape_word_data,
    input wire logic tape_word_ready
);
    // --------------------
    // one domain, reset masks every check
    // --------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // restored input read, then two quiet cycles so only long bits remain
    sequence s_clean_read;
        (input_buffer_read && input_restore_gate && !inhibit_terminate_pulse &&
            input_inhibit == '0) ##1 (!input_buffer_read && !inhibit_terminate_pulse)[*2];
    endsequence

    // --------------------
    // checks
    // --------------------
    a_term_clears: assert property (inhibit_terminate_pulse |=>
        input_inhibit == '0 && output_inhibit == '0) else $error("inhibit survived terminate");
    a_in_inh_hold: assert property (!inhibit_terminate_pulse |=>
        (input_inhibit & $past(input_inhibit)) == $past(input_inhibit))
        else $error("input inhibit dropped early");
    a_out_inh_hold: assert property (!inhibit_terminate_pulse |=>
        (output_inhibit & $past(output_inhibit)) == $past(output_inhibit))
        else $error("output inhibit dropped early");
    a_mside_start: assert property (input_buffer_read |=> mside_out_line == '1)
        else $error("read did not start memory-side pulses");
    a_mside_end: assert property (input_buffer_read ##1 (!input_buffer_read)[*8]
        ##1 !input_buffer_read ##1 !input_buffer_read |=> mside_out_line == '0)
        else $error("memory-side pulse longer than ten cycles");
    a_inh_follows: assert property (s_clean_read |=> input_inhibit == mside_out_line)
        else $error("inhibit differs from bits read out");
    a_tape_start: assert property ($rose(tape_busy) |-> tape_line == '1)
        else $error("tape readout did not start all lines");
    a_tape_end: assert property ($rose(tape_busy) |-> ##20 tape_line == '0)
        else $error("tape pulse not ended after twenty cycles");
    a_word_pushed: assert property ($fell(tape_busy) |-> tape_word_valid)
        else $error("busy dropped without a buffered word");
    a_word_hold: assert property (tape_word_valid && !tape_word_ready |=>
        tape_word_valid && $stable(tape_word_data)) else $error("stalled word changed");

    // main scenarios reached
    cover property (s_clean_read);
    cover property (tape_busy && tape_word_valid && !tape_word_ready);
    cover property ($fell(tape_busy));
endmodule // cbsc_core_buffer_staging_asserts

`default_nettype wire

// file: verif/cbsc_far_side.sv
// far side model: tape readout requester and word consumer
`timescale 1ns/1ps
`default_nettype none

module cbsc_far_side #(
    parameter int W = cbsc_pkg::HALF_WORD_BITS  // bits per half-word
) (
    // clock
    input wire logic clk_sys,
    // requests from the bench
    input wire logic tape_go,
    input wire logic stall,
    // readout request toward the block
    output logic tape_readout_pulse,
    // word stream from the block
    input wire logic tape_word_valid,
    input wire logic [W-1:0] tape_word_data,
    output logic tape_word_ready,
    // word taken at the last edge
    output logic took,
    output logic [W-1:0] took_data
);
    import cbsc_pkg::*;

    int left = 0;  // readout cycles still to drive

    initial begin
        tape_readout_pulse = 1'b0;
        tape_word_ready = 1'b0;
        took = 1'b0;
        took_data = '0;
    end

    // drive off the sampling edge; a new pulse only after a low gap
    always @(negedge clk_sys) begin
        if (tape_go && left == 0 && !tape_readout_pulse)
            left = TAPE_CYC_I;
        tape_readout_pulse <= (left > 0);
        if (left > 0)
            left--;
        tape_word_ready <= !stall;
    end

    // note each completed handshake for the bench
    always @(posedge clk_sys) begin
        took <= tape_word_valid && tape_word_ready;
        took_data <= tape_word_data;
    end
endmodule // cbsc_far_side

`default_nettype wire

// file: verif/tb_core_buffer_staging_control.sv
// self-checking bench for the core buffer staging control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module tb_core_buffer_staging_control;
    import cbsc_pkg::*;

    // --------------------
    // signals and reference model
    // --------------------
    localparam int W = HALF_WORD_BITS;
    localparam logic [11:0] C_PRE_I = 12'h001, C_PRE_O = 12'h002, C_SNS_I = 12'h004;
    localparam logic [11:0] C_SNS_O = 12'h008, C_RD_I = 12'h010, C_RS_I = 12'h020;
    localparam logic [11:0] C_RD_O = 12'h040, C_RS_O = 12'h080, C_TAPE = 12'h100;
    localparam logic [11:0] C_WR_I = 12'h200, C_WR_O = 12'h400, C_TERM = 12'h800;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] ctl = 12'h000;  // sequencing pulses, bit per port
    logic [2:0] stage_addr = 3'h0;
    logic [W-1:0] dist_line = '0;
    logic [W-1:0] mside_in_line = '0;
    logic tape_go = 1'b0;
    logic stall = 1'b0;
    logic [W-1:0] mside_out_line, tape_line, tape_write_ff, input_inhibit, output_inhibit;
    logic [W-1:0] tape_word_data, took_data;
    logic tape_busy, tape_word_valid, tape_word_ready, tape_readout_pulse, took;
    logic [W-1:0] m_inb = '0, m_outb = '0, m_tape = '0, m_iinh = '0, m_oinh = '0, m_mside = '0;
    logic [W-1:0] m_ireg [8] = '{default: '0};  // memory polarity
    logic [W-1:0] m_oreg [8] = '{default: '0};
    logic [W-1:0] q [$];  // words still owed to the far side
    int failures = 0;
    int samples_checked = 0;

    always #50 clk_sys = ~clk_sys;

    cbsc_core_buffer_staging #(.W(W), .DEPTH(STAGE_DEPTH), .QDEPTH(FIFO_DEPTH)) DUT (
        .clk_sys, .rst, .dist_line, .mside_in_line,
        .buffer_preset_in(ctl[0]), .buffer_preset_out(ctl[1]),
        .input_sense_strobe(ctl[2]), .output_sense_strobe(ctl[3]), .stage_addr,
        .input_buffer_read(ctl[4]), .input_restore_gate(ctl[5]),
        .output_buffer_read(ctl[6]), .output_restore_gate(ctl[7]),
        .output_to_tape_transfer(ctl[8]), .input_write_pulse(ctl[9]),
        .output_write_pulse(ctl[10]), .inhibit_terminate_pulse(ctl[11]),
        .tape_readout_pulse, .mside_out_line, .tape_line, .tape_write_ff, .input_inhibit,
        .output_inhibit, .tape_busy, .tape_word_valid, .tape_word_data, .tape_word_ready);

    cbsc_far_side #(.W(W)) u_far (.clk_sys, .tape_go, .stall, .tape_readout_pulse,
        .tape_word_valid, .tape_word_data, .tape_word_ready, .took, .took_data);

    // --------------------
    // tasks
    // --------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle pulse set, model applied in the block's same-cycle order
    task automatic step(input logic [11:0] c, input int a);
        @(negedge clk_sys);
        ctl = c;
        stage_addr = 3'(a);
        @(negedge clk_sys);
        ctl = 12'h000;
        if (c[0]) m_inb = '1;
        if (c[1]) m_outb = '1;
        if (c[2]) m_inb &= ~m_ireg[a];
        if (c[2]) m_ireg[a] = '0;
        if (c[3]) m_outb &= ~m_oreg[a];
        if (c[3]) m_oreg[a] = '0;
        if (c[4] && c[5]) m_iinh |= m_inb;
        if (c[4]) m_mside = m_inb;
        if (c[4]) m_inb = '0;
        if (c[6] && c[8]) m_tape |= m_outb;
        if (c[6] && c[7]) m_oinh |= m_outb;
        if (c[6]) m_outb = '0;
        if (c[9]) m_ireg[a] = ~m_iinh;
        if (c[10]) m_oreg[a] = ~m_oinh;
        if (c[11]) m_iinh = '0;
        if (c[11]) m_oinh = '0;
        `CHK(input_inhibit, m_iinh)
        `CHK(output_inhibit, m_oinh)
    endtask

    // ones held three cycles, zeros only two: the threshold boundary
    task automatic load(input logic side, input logic [W-1:0] v);
        logic [W-1:0] x;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            x = (i < 2) ? '1 : ((i == 2) ? v : '0);
            if (side) mside_in_line = x;
            else dist_line = x;
        end
        if (side) m_outb |= v;
        else m_inb |= v;
    endtask

    // all lines rise, zeros fall after two cycles, ones after ten
    task automatic mside_check;
        `CHK(mside_out_line, {W{1'b1}})
        repeat (2) @(negedge clk_sys);
        `CHK(mside_out_line, m_mside)
        repeat (8) @(negedge clk_sys);
        `CHK(mside_out_line, {W{1'b0}})
    endtask

    // readout request through the far side; refused while busy
    task automatic tape_read(input logic take);
        @(negedge clk_sys);
        tape_go <= 1'b1;
        @(negedge clk_sys);
        tape_go <= 1'b0;
        if (take) begin
            @(negedge clk_sys);  // busy shows one cycle after the rise
            `CHK(tape_line, {W{1'b1}})
            `CHK(tape_write_ff, m_tape)
            repeat (2) @(negedge clk_sys);
            `CHK(tape_line, m_tape)
            q.push_back(m_tape);
            m_tape = '0;
        end else begin
            repeat (2) @(negedge clk_sys);
            `CHK(tape_write_ff, q[$])
            `CHK(tape_busy, 1'b1)
        end
        repeat (22) @(negedge clk_sys);
    endtask

    // words reaching the far side come out in order
    always @(negedge clk_sys) begin
        if (took === 1'b1) begin
            `CHK(took_data, q[0])
            void'(q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        $display("watchdog expired");
        end_sim;
    end

    // --------------------
    // main sequence
    // --------------------
    initial begin
        int a, n;
        logic [W-1:0] v;
        logic side;
        void'($urandom(47));
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        // load, restore, read back, destructive read without restore
        for (int p = 0; p < 2; p++) begin
            side = p[0];
            for (int k = 0; k < 2; k++) begin
                a = $urandom % 8;
                v = W'({$urandom(), $urandom()});
                for (int r = 0; r < 4; r++) begin
                    if (r == 0) load(side, v);
                    if (r > 0) step(side ? C_PRE_O : C_PRE_I, a);
                    if (r > 0) step(side ? C_SNS_O : C_SNS_I, a);
                    step(side ? (C_RD_O | C_TAPE | (r < 2 ? C_RS_O : 12'h000)) :
                        (C_RD_I | (r < 2 ? C_RS_I : 12'h000)), a);
                    if (side) tape_read(1'b1);
                    else mside_check;
                    if (r < 2) step(side ? C_WR_O : C_WR_I, a);
                    if (r < 2) step(C_TERM, a);
                end
            end
            $display("staging path %0d done", p);
        end
        // fill the fifo with the far side stalled, then one refused readout
        stall <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            load(1'b1, W'({$urandom(), $urandom()}));
            step(C_RD_O | C_TAPE, k);
            tape_read(k < 5);
        end
        for (n = 0; n < 400 && q.size() > 0; n++) begin
            @(negedge clk_sys);
            stall <= 1'($urandom % 2);
        end
        stall <= 1'b0;
        tape_read(1'b1);
        `CHK(q.size(), 0)
        $display("fifo test done");
        end_sim;
    end
endmodule // tb_core_buffer_staging_control

bind cbsc_core_buffer_staging cbsc_core_buffer_staging_asserts #(.W(W)) u_asserts (
    .clk_sys, .rst, .input_buffer_read, .input_restore_gate, .inhibit_terminate_pulse,
    .mside_out_line, .tape_line, .input_inhibit, .output_inhibit, .tape_busy,
    .tape_word_valid, .tape_word_data, .tape_word_ready);

`default_nettype wire
